// ==== ccssb_defines.vh ====
`ifndef CCSSB_DEFINES_VH
`define CCSSB_DEFINES_VH

// ****************************************************************
// Register indices, byte address is four times the index
// ****************************************************************
`define CCSSB_IDX_STACK      10'h081
`define CCSSB_IDX_PTR_LO     10'h082
`define CCSSB_IDX_PTR_HI     10'h083
`define CCSSB_IDX_POWER      10'h087
`define CCSSB_IDX_TIMER      10'h088
`define CCSSB_IDX_SERIAL     10'h098
`define CCSSB_IDX_IRQ_STAT   10'h0c0
`define CCSSB_IDX_IRQ_MASK   10'h0c1

// ****************************************************************
// Reset values
// ****************************************************************
`define CCSSB_RST_STACK      8'h07
`define CCSSB_RST_PTR        8'h00
`define CCSSB_RST_TIMER      8'h00
`define CCSSB_RST_IRQ        6'h00

// ****************************************************************
// Power control field positions
// ****************************************************************
`define CCSSB_PWR_BAUD       7
`define CCSSB_PWR_FESEL      6
`define CCSSB_PWR_BROWN      5
`define CCSSB_PWR_POR        4
`define CCSSB_PWR_UFB        3
`define CCSSB_PWR_UFA        2
`define CCSSB_PWR_PDOWN      1
`define CCSSB_PWR_HALT       0

// ****************************************************************
// Timer control field positions, timer 1 sits one stride above
// ****************************************************************
`define CCSSB_TMR_OVF0       5
`define CCSSB_TMR_RUN0       4
`define CCSSB_TMR_EXTF0      1
`define CCSSB_TMR_EXTT0      0
`define CCSSB_TMR_STRIDE     2

// ****************************************************************
// Serial control top bit, interrupt status layout
// ****************************************************************
`define CCSSB_SER_TOP        7
`define CCSSB_IRQ_OVF0       0
`define CCSSB_IRQ_EXT0       2
`define CCSSB_IRQ_BROWN      4
`define CCSSB_IRQ_FRAME      5
`define CCSSB_IRQ_W          6

// ****************************************************************
// Bus answers and decoder selects
// ****************************************************************
`define CCSSB_RESP_OKAY      2'b00
`define CCSSB_RESP_SLVERR    2'b10
`define CCSSB_SEL_NONE       4'h0
`define CCSSB_SEL_STACK      4'h1
`define CCSSB_SEL_PTR_LO     4'h2
`define CCSSB_SEL_PTR_HI     4'h3
`define CCSSB_SEL_POWER      4'h4
`define CCSSB_SEL_TIMER      4'h5
`define CCSSB_SEL_SERIAL     4'h6
`define CCSSB_SEL_IRQ_STAT   4'h7
`define CCSSB_SEL_IRQ_MASK   4'h8

`endif

// ==== ccssb_bank.v ====
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ccssb_defines.vh"

module ccssb_bank (
  input  wire        clk_sys,           // System clock, 20 MHz
  input  wire        resetn,            // Power-on reset, async, active low
  // AXI4-Lite slave
  input  wire [11:0] s_axi_awaddr,      // Write address
  input  wire        s_axi_awvalid,     // Write address valid
  output wire        s_axi_awready,     // Write address ready
  input  wire [31:0] s_axi_wdata,       // Write data
  input  wire [3:0]  s_axi_wstrb,       // Write byte strobes
  input  wire        s_axi_wvalid,      // Write data valid
  output wire        s_axi_wready,      // Write data ready
  output wire [1:0]  s_axi_bresp,       // Write response
  output wire        s_axi_bvalid,      // Write response valid
  input  wire        s_axi_bready,      // Write response ready
  input  wire [11:0] s_axi_araddr,      // Read address
  input  wire        s_axi_arvalid,     // Read address valid
  output wire        s_axi_arready,     // Read address ready
  output wire [31:0] s_axi_rdata,       // Read data
  output wire [1:0]  s_axi_rresp,       // Read response
  output wire        s_axi_rvalid,      // Read data valid
  input  wire        s_axi_rready,      // Read data ready
  // Events from neighbouring blocks, same clock
  input  wire        timer0Overflow,    // Timer 0 overflow pulse
  input  wire        timer1Overflow,    // Timer 1 overflow pulse
  input  wire        timer0Vector,      // Timer 0 service entered pulse
  input  wire        timer1Vector,      // Timer 1 service entered pulse
  input  wire        extIrq0Vector,     // External 0 service entered pulse
  input  wire        extIrq1Vector,     // External 1 service entered pulse
  input  wire        brownoutEvent,     // Brownout reset or interrupt pulse
  input  wire        frameErrorEvent,   // Serial frame error pulse
  input  wire        wakeEvent,         // Leaves halt or power-down
  // External interrupt pins, asynchronous
  input  wire        extIrq0Pin,        // External interrupt 0 pin
  input  wire        extIrq1Pin,        // External interrupt 1 pin
  // Outputs to the core
  output wire [7:0]  stackTopPointer,   // Stack top address
  output wire [15:0] dataPointer,       // Sixteen-bit data pointer
  output wire        baudDoubler,       // Serial baud doubling
  output wire        frameErrorSelect,  // Top serial bit is frame flag
  output wire        serialModeBit,     // Serial mode bit to serial block
  output wire        cpuClockEnable,    // CPU clock gate enable
  output wire        periphClockEnable, // Serial/timer/irq clock gate enable
  output wire        powerDownRequest,  // Power-down mode requested
  output wire        cpuHaltRequest,    // Halt mode requested
  output wire [1:0]  timerRun,          // Run bits, timer 1 high
  output wire [1:0]  timerOverflowFlag, // Overflow flags, timer 1 high
  output wire [1:0]  extIrqFlag,        // External flags, line 1 high
  output wire        irq                // Level interrupt, unmasked status
);

  // ****************************************************************
  // Address decode
  // ****************************************************************

  // Only the word index is decoded; unknown words get a select of none
  function [3:0] decodeSel;
    input [11:0] addr;
    begin
      case (addr[11:2])
        `CCSSB_IDX_STACK:    decodeSel = `CCSSB_SEL_STACK;
        `CCSSB_IDX_PTR_LO:   decodeSel = `CCSSB_SEL_PTR_LO;
        `CCSSB_IDX_PTR_HI:   decodeSel = `CCSSB_SEL_PTR_HI;
        `CCSSB_IDX_POWER:    decodeSel = `CCSSB_SEL_POWER;
        `CCSSB_IDX_TIMER:    decodeSel = `CCSSB_SEL_TIMER;
        `CCSSB_IDX_SERIAL:   decodeSel = `CCSSB_SEL_SERIAL;
        `CCSSB_IDX_IRQ_STAT: decodeSel = `CCSSB_SEL_IRQ_STAT;
        `CCSSB_IDX_IRQ_MASK: decodeSel = `CCSSB_SEL_IRQ_MASK;
        default:             decodeSel = `CCSSB_SEL_NONE;
      endcase
    end
  endfunction

  // ****************************************************************
  // Register state
  // ****************************************************************
  reg  [7:0]  stack_r;
  reg  [7:0]  ptrLo_r;
  reg  [7:0]  ptrHi_r;
  reg         baud_r;
  reg         feSel_r;
  reg         brown_r;
  reg         brown_nxt;
  reg         por_r;
  reg         por_nxt;
  reg  [1:0]  userFlag_r;
  reg         pdown_r;
  reg         pdown_nxt;
  reg         halt_r;
  reg         halt_nxt;
  reg  [1:0]  ovf_r;
  reg  [1:0]  ovf_nxt;
  reg  [1:0]  run_r;
  reg  [1:0]  extF_r;
  reg  [1:0]  extF_nxt;
  reg  [1:0]  extT_r;
  reg         serMode_r;
  reg         feFlag_r;
  reg         feFlag_nxt;
  reg  [`CCSSB_IRQ_W-1:0] irqStat_r;
  reg  [`CCSSB_IRQ_W-1:0] irqStat_nxt;
  reg  [`CCSSB_IRQ_W-1:0] irqMask_r;
  reg  [`CCSSB_IRQ_W-1:0] irqEvent;

  // Bus channel state
  reg         awHave_r;
  reg  [11:0] awAddr_r;
  reg         wHave_r;
  reg  [7:0]  wByte_r;
  reg         wLane_r;
  reg         bValid_r;
  reg  [1:0]  bResp_r;
  reg         rValid_r;
  reg  [31:0] rData_r;
  reg  [1:0]  rResp_r;

  // Pin synchronisers, previous sample for edge detection
  reg  [1:0]  pinMeta_r;
  reg  [1:0]  pinSync_r;
  reg  [1:0]  pinPrev_r;

  wire [1:0]  timerOvfIn = {timer1Overflow, timer0Overflow};
  wire [1:0]  timerVecIn = {timer1Vector, timer0Vector};
  wire [1:0]  extVecIn   = {extIrq1Vector, extIrq0Vector};

  // ****************************************************************
  // Write channel
  // ****************************************************************

  // Address and data are taken in either order, response waits for both
  assign s_axi_awready = ~awHave_r & ~bValid_r;
  assign s_axi_wready  = ~wHave_r & ~bValid_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;

  wire        wrFire = awHave_r & wHave_r & ~bValid_r;
  wire [3:0]  wrSel  = decodeSel(awAddr_r);
  wire [7:0]  wrByte = wByte_r;
  // Registers are one byte wide, so only lane 0 carries a write
  wire        wrGo   = wrFire & wLane_r;
  wire        wrPower  = wrGo & (wrSel == `CCSSB_SEL_POWER);
  wire        wrTimer  = wrGo & (wrSel == `CCSSB_SEL_TIMER);
  wire        wrSerial = wrGo & (wrSel == `CCSSB_SEL_SERIAL);

  // Channel capture and response
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      awHave_r <= 1'b0;
      awAddr_r <= 12'h000;
      wHave_r  <= 1'b0;
      wByte_r  <= 8'h00;
      wLane_r  <= 1'b0;
      bValid_r <= 1'b0;
      bResp_r  <= `CCSSB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_r <= 1'b1;
        wByte_r <= s_axi_wdata[7:0];
        wLane_r <= s_axi_wstrb[0];
      end
      if (wrFire) begin
        awHave_r <= 1'b0;
        wHave_r  <= 1'b0;
        bValid_r <= 1'b1;
        bResp_r  <= (wrSel == `CCSSB_SEL_NONE) ? `CCSSB_RESP_SLVERR : `CCSSB_RESP_OKAY;
      end else if (bValid_r && s_axi_bready) begin
        bValid_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  assign s_axi_arready = ~rValid_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;

  wire [7:0] powerView = {baud_r, feSel_r, brown_r, por_r, userFlag_r, pdown_r, halt_r};
  wire [7:0] timerView = {ovf_r[1], run_r[1], ovf_r[0], run_r[0],
                          extF_r[1], extT_r[1], extF_r[0], extT_r[0]};
  wire       serTopView = feSel_r ? feFlag_r : serMode_r;

  // Read mux, reads have no side effects
  reg  [7:0] rdByte;
  wire [3:0] rdSel = decodeSel(s_axi_araddr);
  always @* begin
    rdByte = 8'h00;
    case (rdSel)
      `CCSSB_SEL_STACK:    rdByte = stack_r;
      `CCSSB_SEL_PTR_LO:   rdByte = ptrLo_r;
      `CCSSB_SEL_PTR_HI:   rdByte = ptrHi_r;
      `CCSSB_SEL_POWER:    rdByte = powerView;
      `CCSSB_SEL_TIMER:    rdByte = timerView;
      `CCSSB_SEL_SERIAL:   rdByte = {serTopView, 7'h00};
      `CCSSB_SEL_IRQ_STAT: rdByte = {2'b00, irqStat_r};
      `CCSSB_SEL_IRQ_MASK: rdByte = {2'b00, irqMask_r};
      default:             rdByte = 8'h00;
    endcase
  end

  // Read data registered, answer one cycle after address taken
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rValid_r <= 1'b0;
      rData_r  <= 32'h00000000;
      rResp_r  <= `CCSSB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_r <= 1'b1;
      rData_r  <= {24'h000000, rdByte};
      rResp_r  <= (rdSel == `CCSSB_SEL_NONE) ? `CCSSB_RESP_SLVERR : `CCSSB_RESP_OKAY;
    end else if (rValid_r && s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  // Two flops before use; edge detect compares second and third stage
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pinMeta_r <= 2'b11;
      pinSync_r <= 2'b11;
      pinPrev_r <= 2'b11;
    end else begin
      pinMeta_r <= {extIrq1Pin, extIrq0Pin};
      pinSync_r <= pinMeta_r;
      pinPrev_r <= pinSync_r;
    end
  end

  // ****************************************************************
  // Timer control next state
  // ****************************************************************

  // Priority: vector clear, then software write, then hardware set wins
  integer i;
  always @* begin
    ovf_nxt  = ovf_r;
    extF_nxt = extF_r;
    for (i = 0; i < 2; i = i + 1) begin
      if (timerVecIn[i])
        ovf_nxt[i] = 1'b0;
      if (wrTimer)
        ovf_nxt[i] = wrByte[`CCSSB_TMR_OVF0 + `CCSSB_TMR_STRIDE * i];
      if (timerOvfIn[i])
        ovf_nxt[i] = 1'b1;
      if (extT_r[i]) begin
        if (extVecIn[i])
          extF_nxt[i] = 1'b0;
        if (wrTimer)
          extF_nxt[i] = wrByte[`CCSSB_TMR_EXTF0 + `CCSSB_TMR_STRIDE * i];
        if (pinPrev_r[i] && !pinSync_r[i])
          extF_nxt[i] = 1'b1;
      end else begin
        extF_nxt[i] = ~pinSync_r[i];
      end
    end
  end

  // Timer control storage
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ovf_r  <= 2'b00;
      run_r  <= 2'b00;
      extF_r <= 2'b00;
      extT_r <= 2'b00;
    end else begin
      ovf_r  <= ovf_nxt;
      extF_r <= extF_nxt;
      if (wrTimer) begin
        run_r  <= {wrByte[`CCSSB_TMR_RUN0 + `CCSSB_TMR_STRIDE], wrByte[`CCSSB_TMR_RUN0]};
        extT_r <= {wrByte[`CCSSB_TMR_EXTT0 + `CCSSB_TMR_STRIDE], wrByte[`CCSSB_TMR_EXTT0]};
      end
    end
  end

  // ****************************************************************
  // Power control and serial top bit
  // ****************************************************************

  // Sticky cause flags: a write of one is ignored, the event beats a clear
  always @* begin
    brown_nxt  = brown_r;
    por_nxt    = por_r;
    pdown_nxt  = pdown_r;
    halt_nxt   = halt_r;
    feFlag_nxt = feFlag_r;
    if (wrPower) begin
      brown_nxt = brown_r & wrByte[`CCSSB_PWR_BROWN];
      por_nxt   = por_r & wrByte[`CCSSB_PWR_POR];
      pdown_nxt = wrByte[`CCSSB_PWR_PDOWN];
      halt_nxt  = wrByte[`CCSSB_PWR_HALT];
    end
    // Wake-up ends both low power modes
    if (wakeEvent) begin
      pdown_nxt = 1'b0;
      halt_nxt  = 1'b0;
    end
    if (brownoutEvent)
      brown_nxt = 1'b1;
    if (wrSerial && feSel_r)
      feFlag_nxt = wrByte[`CCSSB_SER_TOP];
    if (frameErrorEvent)
      feFlag_nxt = 1'b1;
  end

  // brownout and power-on cause flags start set at power on
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      baud_r     <= 1'b0;
      feSel_r    <= 1'b0;
      brown_r    <= 1'b1;
      por_r      <= 1'b1;
      userFlag_r <= 2'b00;
      pdown_r    <= 1'b0;
      halt_r     <= 1'b0;
      serMode_r  <= 1'b0;
      feFlag_r   <= 1'b0;
    end else begin
      brown_r  <= brown_nxt;
      por_r    <= por_nxt;
      pdown_r  <= pdown_nxt;
      halt_r   <= halt_nxt;
      feFlag_r <= feFlag_nxt;
      if (wrPower) begin
        baud_r     <= wrByte[`CCSSB_PWR_BAUD];
        feSel_r    <= wrByte[`CCSSB_PWR_FESEL];
        userFlag_r <= {wrByte[`CCSSB_PWR_UFB], wrByte[`CCSSB_PWR_UFA]};
      end
      // mode bit written when not selected
      if (wrSerial && !feSel_r)
        serMode_r <= wrByte[`CCSSB_SER_TOP];
    end
  end

  // ****************************************************************
  // Pointer registers
  // ****************************************************************
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stack_r <= `CCSSB_RST_STACK;
      ptrLo_r <= `CCSSB_RST_PTR;
      ptrHi_r <= `CCSSB_RST_PTR;
    end else if (wrGo) begin
      if (wrSel == `CCSSB_SEL_STACK)
        stack_r <= wrByte;
      if (wrSel == `CCSSB_SEL_PTR_LO)
        ptrLo_r <= wrByte;
      if (wrSel == `CCSSB_SEL_PTR_HI)
        ptrHi_r <= wrByte;
    end
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************

  // Timer and external events are flag rises, so a software set of those flags also counts
  always @* begin
    irqEvent = `CCSSB_RST_IRQ;
    irqEvent[`CCSSB_IRQ_OVF0 +: 2] = ovf_nxt & ~ovf_r;
    irqEvent[`CCSSB_IRQ_EXT0 +: 2] = extF_nxt & ~extF_r;
    irqEvent[`CCSSB_IRQ_BROWN]     = brownoutEvent;
    irqEvent[`CCSSB_IRQ_FRAME]     = frameErrorEvent;
    irqStat_nxt = irqStat_r;
    if (wrGo && (wrSel == `CCSSB_SEL_IRQ_STAT))
      irqStat_nxt = irqStat_r & ~wrByte[`CCSSB_IRQ_W-1:0];
    // Set beats the write-one clear in the same cycle
    irqStat_nxt = irqStat_nxt | irqEvent;
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irqStat_r <= `CCSSB_RST_IRQ;
      irqMask_r <= `CCSSB_RST_IRQ;
    end else begin
      irqStat_r <= irqStat_nxt;
      if (wrGo && (wrSel == `CCSSB_SEL_IRQ_MASK))
        irqMask_r <= wrByte[`CCSSB_IRQ_W-1:0];
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign stackTopPointer   = stack_r;
  assign dataPointer       = {ptrHi_r, ptrLo_r};
  assign baudDoubler       = baud_r;
  assign frameErrorSelect  = feSel_r;
  assign serialModeBit     = serMode_r;
  assign periphClockEnable = ~pdown_r;
  assign cpuClockEnable    = ~(pdown_r | halt_r);
  assign powerDownRequest  = pdown_r;
  assign cpuHaltRequest    = halt_r;
  assign timerRun          = run_r;
  assign timerOverflowFlag = ovf_r;
  assign extIrqFlag        = extF_r;
  // Level interrupt, stays high until status cleared or masked
  assign irq               = |(irqStat_r & irqMask_r);

endmodule // ccssb_bank

// ==== ccssb_bank_notes_unused.v ====
// Spare file, all bank logic lives in the main design file

// ==== ccssb_bank_properties.sv ====
`timescale 1ns/1ps
// ****
// Port checker
// ****
module ccssb_bank_properties (
  input wire       clk_sys,           // Clock
  input wire       resetn,            // Reset
  input wire       s_axi_awvalid,     // Bus
  input wire       s_axi_awready,     // Bus
  input wire       s_axi_wvalid,      // Bus
  input wire       s_axi_wready,      // Bus
  input wire       s_axi_bvalid,      // Bus
  input wire       timer0Overflow,    // Event
  input wire       timer1Overflow,    // Event
  input wire       timer1Vector,      // Event
  input wire       wakeEvent,         // Event
  input wire [7:0] stackTopPointer,   // Output
  input wire [1:0] timerRun,          // Output
  input wire [1:0] timerOverflowFlag, // Output
  input wire       cpuClockEnable,    // Output
  input wire       periphClockEnable, // Output
  input wire       powerDownRequest,  // Output
  input wire       cpuHaltRequest     // Output
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Store happens one edge after both channels are taken
  sequence sBothTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence sLateAnswer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  // Free of a store: vector and wake cannot be overruled by a write
  sequence sNoStore;
    s_axi_awready && s_axi_wready;
  endsequence
  a_write_answer_time: assert property (sBothTaken |=> sLateAnswer)
    else $error("write answer not two edges after both channels taken");
  a_pdown_stops_all: assert property (
    powerDownRequest |-> !cpuClockEnable && !periphClockEnable)
    else $error("power-down left a clock running");
  a_halt_cpu_only: assert property (
    cpuHaltRequest && !powerDownRequest |-> !cpuClockEnable && periphClockEnable)
    else $error("halt gated the wrong clocks");
  a_ovf_sets_flag: assert property (
    timer0Overflow |=> timerOverflowFlag[0])
    else $error("overflow did not set flag");
  a_vector_clears_ovf: assert property (
    ((timer1Vector && !timer1Overflow) and sNoStore) |=> !timerOverflowFlag[1])
    else $error("vector did not clear overflow flag");
  a_flag_rise_cause: assert property (
    $rose(timerOverflowFlag[0]) |-> $past(timer0Overflow) || $rose(s_axi_bvalid))
    else $error("overflow flag rose without cause");
  a_run_by_write: assert property (
    !$stable(timerRun) |-> $rose(s_axi_bvalid))
    else $error("run bits changed without a store");
  a_stack_by_write: assert property (
    !$stable(stackTopPointer) |-> $rose(s_axi_bvalid))
    else $error("stack pointer changed without a store");
  a_wake_clears_modes: assert property (
    (wakeEvent and sNoStore) |=> !powerDownRequest && !cpuHaltRequest)
    else $error("wake left a low-power request set");
endmodule // ccssb_bank_properties

bind ccssb_bank ccssb_bank_properties i_props (.clk_sys, .resetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .timer0Overflow,
  .timer1Overflow, .timer1Vector, .wakeEvent, .stackTopPointer, .timerRun,
  .timerOverflowFlag, .cpuClockEnable, .periphClockEnable, .powerDownRequest,
  .cpuHaltRequest);

// ==== ccssb_bank_tb_top.sv ====
`timescale 1ns/1ps
`define CK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end

module ccssb_bank_tb_top;
  int n_fail = 0;
  int compares = 0;
  logic [7:0] rdv;
  logic [1:0] rsp;
  logic clk_sys = 1'h0, resetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [8:0] ev = 9'h0;
  wire timer0Overflow, timer1Overflow, timer0Vector, timer1Vector, extIrq0Vector;
  wire extIrq1Vector, brownoutEvent, frameErrorEvent, wakeEvent;
  // One bit per event input, so a single pulse task serves them all
  assign {wakeEvent, frameErrorEvent, brownoutEvent, extIrq1Vector, extIrq0Vector,
          timer1Vector, timer0Vector, timer1Overflow, timer0Overflow} = ev;
  localparam int T0OVF = 0, T1OVF = 1, T0VEC = 2, T1VEC = 3, X0VEC = 4;
  localparam int X1VEC = 5, BROWN = 6, FRAME = 7, WAKE = 8;
  logic extIrq0Pin = 1'h1, extIrq1Pin = 1'h1;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire baudDoubler, frameErrorSelect, serialModeBit, cpuClockEnable, periphClockEnable;
  wire powerDownRequest, cpuHaltRequest;
  wire [1:0] s_axi_bresp, s_axi_rresp, timerRun, timerOverflowFlag, extIrqFlag;
  wire [31:0] s_axi_rdata;
  wire [7:0] stackTopPointer;
  wire [15:0] dataPointer;

  ccssb_bank i_dut (.*);

  // 20 MHz clock
  always #25 clk_sys = ~clk_sys;

  // ****
  // Bus and event helpers
  // ****
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic pulse(input int k);
    @(posedge clk_sys);
    ev[k] <= 1'h1;
    @(posedge clk_sys);
    ev[k] <= 1'h0;
  endtask
  // Readiness sampled mid-cycle equals its value at the next rising edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge clk_sys);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end while (!tb);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a);
    logic ta, tr;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge clk_sys);
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      rdv = s_axi_rdata[7:0];
      rsp = s_axi_rresp;
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'h0;
    end while (!tr);
    s_axi_rready <= 1'h0;
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    rd(12'h204); `CK(rdv, 8'h07)
    rd(12'h21c); `CK(rdv, 8'h30)
    `CK(dataPointer, 16'h0000)
  endtask
  task automatic t_regs;
    wr(12'h204, 8'ha5);
    wr(12'h208, 8'h34);
    wr(12'h20c, 8'h12);
    tick(0);
    `CK(stackTopPointer, 8'ha5)
    `CK(dataPointer, 16'h1234)
    wr(12'h3f0, 8'hff); `CK(rsp, 2'h2)
    rd(12'h000); `CK({rsp, rdv}, 10'h200)
  endtask
  task automatic t_power;
    wr(12'h21c, 8'h00);
    rd(12'h21c); `CK(rdv, 8'h00)
    pulse(BROWN);
    rd(12'h21c); `CK(rdv, 8'h20)
    wr(12'h21c, 8'h01); tick(0);
    `CK({cpuHaltRequest, cpuClockEnable, periphClockEnable}, 3'h5)
    pulse(WAKE); tick(0); `CK(cpuClockEnable, 1'h1)
    wr(12'h21c, 8'h02); tick(0);
    `CK({powerDownRequest, cpuClockEnable, periphClockEnable}, 3'h4)
    pulse(WAKE);
  endtask
  // Unmask only timer 0 so the interrupt line shows its status bit
  task automatic t_timer;
    wr(12'h304, 8'h01);
    pulse(T0OVF); tick(0); `CK({timerOverflowFlag, irq}, 3'h3)
    // Clear every status bit, the brownout one is still set from before
    wr(12'h300, 8'h3f);
    pulse(T0VEC); tick(0); `CK({timerOverflowFlag, irq}, 3'h0)
    wr(12'h220, 8'hf0); tick(0); `CK({timerOverflowFlag, timerRun, irq}, 5'h1f)
    rd(12'h300); `CK(rdv, 8'h03)
    pulse(T1VEC); tick(0); `CK(timerOverflowFlag, 2'h1)
    pulse(T1OVF); tick(0); `CK(timerOverflowFlag, 2'h3)
    wr(12'h220, 8'h00);
    wr(12'h300, 8'h3f); tick(0); `CK({timerOverflowFlag, timerRun, irq}, 5'h00)
  endtask
  task automatic t_ext;
    @(posedge clk_sys);
    extIrq0Pin <= 1'h0;
    tick(4); `CK(extIrqFlag, 2'h1)
    pulse(X0VEC); tick(0); `CK(extIrqFlag, 2'h1)
    @(posedge clk_sys);
    extIrq0Pin <= 1'h1;
    tick(4); `CK(extIrqFlag, 2'h0)
    wr(12'h220, 8'h05);
    @(posedge clk_sys);
    extIrq1Pin <= 1'h0;
    tick(4); `CK(extIrqFlag, 2'h2)
    @(posedge clk_sys);
    extIrq1Pin <= 1'h1;
    tick(4); `CK(extIrqFlag, 2'h2)
    pulse(X1VEC); tick(0); `CK(extIrqFlag, 2'h0)
  endtask
  task automatic t_serial;
    wr(12'h260, 8'h80); tick(0); `CK(serialModeBit, 1'h1)
    wr(12'h21c, 8'hc0);
    rd(12'h260); `CK({baudDoubler, frameErrorSelect, rdv}, 10'h300)
    pulse(FRAME);
    rd(12'h260); `CK(rdv, 8'h80)
  endtask

  // Verdict and stop
  task automatic end_sim;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Main sequence after 12 cycles of reset
  initial begin
    repeat (12) @(posedge clk_sys);
    resetn <= 1'h1;
    t_reset;
    t_regs;
    t_power;
    t_timer;
    t_ext;
    t_serial;
    end_sim;
  end
  // Watchdog, far beyond the fewer than 200 cycles the run needs
  initial begin
    repeat (4000) @(posedge clk_sys);
    n_fail++;
    end_sim;
  end
endmodule // ccssb_bank_tb_top
